// ---- hdl/mih_pkg.sv ----
// Package: register map, fields and timing of the interrupt handler
package mih_pkg;
   localparam int NUM_SRC = 17;
   localparam logic [11:0] ADDR_ENABLE = 12'h000;
   localparam logic [11:0] ADDR_ENABLE_EXT = 12'h004;
   localparam logic [11:0] ADDR_PRIO = 12'h008;
   localparam logic [11:0] ADDR_PRIO_EXT = 12'h00c;
   localparam logic [11:0] ADDR_TIMER_CTRL = 12'h010;
   localparam logic [11:0] ADDR_EXT_CFG = 12'h014;
   localparam logic [11:0] ADDR_PENDING = 12'h018;
   localparam logic [11:0] ADDR_STATUS = 12'h01c;
   localparam logic [11:0] ADDR_MASK = 12'h020;
   localparam logic [11:0] ADDR_VECTOR = 12'h024;
   localparam int GLOBAL_EN_BIT = 7;
   localparam int EXT0_EDGE_BIT = 0;
   localparam int EXT0_FLAG_BIT = 1;
   localparam int EXT1_EDGE_BIT = 2;
   localparam int EXT1_FLAG_BIT = 3;
   localparam int EXT0_POL_BIT = 3;
   localparam int EXT1_POL_BIT = 7;
   localparam int SRC_EXT0 = 0;
   localparam int SRC_EXT1 = 2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] VECTOR_BASE = 16'h0003;
   localparam logic [15:0] VECTOR_STEP = 16'h0008;
   localparam int DETECT_CYCLES = 1;
   localparam int CALL_CYCLES = 5;
   localparam logic [1:0] ST_TAKEN_BIT = 2'd0;
   localparam logic [1:0] ST_RETURN_BIT = 2'd1;
   typedef struct packed {
      logic valid;
      logic high;
      logic [4:0] src;
   } mih_req_type;
endpackage

// ---- hdl/mih_top.sv ----
// Interrupt handler: pending flags, enables, priority decode and CPU vectoring
// Operation
// - Source event sets its pending flag regardless of enable state.
// - Enabled pending source raises request; CPU long-calls its vector after instruction.
// - Return restores the interrupted flow; the level stack pops.
// - Disabled sources never raise requests.
// - Global enable bit 7 gates every per-source enable.
// - Only external edge flags clear on vectoring; level external flags follow the pin, others wait for software.
// - Flag still set after return re-requests after one more instruction.
// - Software writing one to a flag requests like hardware.
// - Seventeen sources, each with a low or high priority bit.
// - Sense bit picks edge or level; polarity bit picks active level.
// - Config register selects the watched pin, sampled without driving it.
// - External flags sit at bits 1 and 3 of timer control.
// - Edge external flags clear by hardware on vectoring.
// - Level external flags mirror the active state of the pin.
// - High preempts low, nothing preempts high, fixed order breaks ties.
// - Decode every cycle; vector issued after detect plus five call cycles.
// - Equal or higher running level blocks until return plus one instruction.
`timescale 1ns/1ns
`default_nettype none
module mih_top (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic [31:0] PRDATA,
   input wire logic [16:0] SRC_EVENT,
   input wire logic [7:0] PORT_PINS,
   input wire logic INSTR_DONE,
   input wire logic RETURN_DONE,
   output logic CALL_REQ,
   output logic [15:0] CALL_VECTOR,
   output logic IRQ
);
   localparam int N = mih_pkg::NUM_SRC;
   logic [N-1:0] pend_reg, pend_next, en_reg, prio_reg;
   logic global_reg;
   logic [3:0] tctl_reg;
   logic [7:0] cfg_reg;
   logic [1:0] level_reg;
   logic [1:0] ext_prev_reg;
   logic call_reg;
   logic [2:0] call_cnt_reg;
   logic [4:0] call_src_reg;
   logic call_high_reg;
   logic [15:0] vec_reg;
   logic block_reg;
   logic [1:0] sts_reg, mask_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rd_mux;
   mih_pkg::mih_req_type req;
   ////////////////////////////////////////////////////////////////////
   // Bus decode
   wire wr = PSEL && PENABLE && PWRITE;
   // Read data captured in setup so it stands through the access phase
   wire rd_setup = PSEL && !PENABLE && !PWRITE;
   wire [11:0] a = PADDR;
   wire hit = a == mih_pkg::ADDR_ENABLE || a == mih_pkg::ADDR_ENABLE_EXT || a == mih_pkg::ADDR_PRIO
      || a == mih_pkg::ADDR_PRIO_EXT || a == mih_pkg::ADDR_TIMER_CTRL || a == mih_pkg::ADDR_EXT_CFG
      || a == mih_pkg::ADDR_PENDING || a == mih_pkg::ADDR_STATUS || a == mih_pkg::ADDR_MASK
      || a == mih_pkg::ADDR_VECTOR;
   wire wr_en = wr && a == mih_pkg::ADDR_ENABLE;
   wire wr_enx = wr && a == mih_pkg::ADDR_ENABLE_EXT;
   wire wr_pr = wr && a == mih_pkg::ADDR_PRIO;
   wire wr_prx = wr && a == mih_pkg::ADDR_PRIO_EXT;
   wire wr_tc = wr && a == mih_pkg::ADDR_TIMER_CTRL;
   wire wr_cfg = wr && a == mih_pkg::ADDR_EXT_CFG;
   wire wr_pend = wr && a == mih_pkg::ADDR_PENDING;
   wire wr_sts = wr && a == mih_pkg::ADDR_STATUS;
   wire wr_mask = wr && a == mih_pkg::ADDR_MASK;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !hit;
   assign PRDATA = rdata_reg;
   ////////////////////////////////////////////////////////////////////
   // External inputs
   // Pin select is read-only sampling; nothing here drives a pin
   wire [2:0] sel0 = cfg_reg[2:0];
   wire [2:0] sel1 = cfg_reg[6:4];
   wire pol0 = cfg_reg[mih_pkg::EXT0_POL_BIT];
   wire pol1 = cfg_reg[mih_pkg::EXT1_POL_BIT];
   wire edge0 = tctl_reg[mih_pkg::EXT0_EDGE_BIT];
   wire edge1 = tctl_reg[mih_pkg::EXT1_EDGE_BIT];
   wire act0 = PORT_PINS[sel0] == pol0;
   wire act1 = PORT_PINS[sel1] == pol1;
   wire [1:0] ext_act = {act1, act0};
   wire [1:0] ext_rise = ext_act & ~ext_prev_reg;
   wire [1:0] ext_edge = {edge1, edge0};
   wire [1:0] ext_set = ext_edge & ext_rise;
   ////////////////////////////////////////////////////////////////////
   // Priority decode, every cycle
   wire [N-1:0] live = pend_reg & en_reg & {N{global_reg}};
   wire [N-1:0] live_hi = live & prio_reg;
   // Lowest index wins within a level
   always_comb begin
      req = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (live[i]) begin
            req.valid = 1'b1;
            req.src = 5'(i);
            req.high = 1'b0;
         end
      end
      for (int i = N - 1; i >= 0; i--) begin
         if (live_hi[i]) begin
            req.valid = 1'b1;
            req.src = 5'(i);
            req.high = 1'b1;
         end
      end
   end
   wire running_low = level_reg[0];
   wire running_high = level_reg[1];
   wire allowed = req.valid && !running_high && (!running_low || req.high);
   wire start = allowed && INSTR_DONE && !call_reg && !block_reg;
   wire call_last = call_reg && call_cnt_reg == 3'(mih_pkg::CALL_CYCLES - 1);
   wire [15:0] vec_calc = mih_pkg::VECTOR_BASE + 16'(req.src) * mih_pkg::VECTOR_STEP;
   ////////////////////////////////////////////////////////////////////
   // Pending flags
   always_comb begin
      pend_next = pend_reg;
      if (wr_pend) pend_next = pend_reg | PWDATA[N-1:0];
      if (wr_tc) begin
         pend_next[mih_pkg::SRC_EXT0] = PWDATA[mih_pkg::EXT0_FLAG_BIT];
         pend_next[mih_pkg::SRC_EXT1] = PWDATA[mih_pkg::EXT1_FLAG_BIT];
      end
      if (wr_pend) begin
         for (int i = 0; i < N; i++) if (!PWDATA[i] && PWDATA[31]) pend_next[i] = 1'b0;
      end
      if (call_last && call_src_reg == 5'(mih_pkg::SRC_EXT0) && edge0) pend_next[mih_pkg::SRC_EXT0] = 1'b0;
      if (call_last && call_src_reg == 5'(mih_pkg::SRC_EXT1) && edge1) pend_next[mih_pkg::SRC_EXT1] = 1'b0;
      pend_next = pend_next | SRC_EVENT;
      if (ext_set[0]) pend_next[mih_pkg::SRC_EXT0] = 1'b1;
      if (ext_set[1]) pend_next[mih_pkg::SRC_EXT1] = 1'b1;
      if (!edge0) pend_next[mih_pkg::SRC_EXT0] = act0;
      if (!edge1) pend_next[mih_pkg::SRC_EXT1] = act1;
   end
   ////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pend_reg <= '0;
         en_reg <= '0;
         prio_reg <= '0;
         global_reg <= 1'b0;
         tctl_reg <= '0;
         cfg_reg <= mih_pkg::RESET_BYTE;
         ext_prev_reg <= '0;
         sts_reg <= '0;
         mask_reg <= '0;
         rdata_reg <= '0;
      end else if (CLK_EN) begin
         pend_reg <= pend_next;
         ext_prev_reg <= ext_act;
         if (wr_en) {global_reg, en_reg[6:0]} <= PWDATA[7:0];
         if (wr_enx) en_reg[N-1:7] <= PWDATA[N-8:0];
         if (wr_pr) prio_reg[6:0] <= PWDATA[6:0];
         if (wr_prx) prio_reg[N-1:7] <= PWDATA[N-8:0];
         if (wr_tc) begin
            tctl_reg[mih_pkg::EXT0_EDGE_BIT] <= PWDATA[mih_pkg::EXT0_EDGE_BIT];
            tctl_reg[mih_pkg::EXT1_EDGE_BIT] <= PWDATA[mih_pkg::EXT1_EDGE_BIT];
         end
         if (wr_cfg) cfg_reg <= PWDATA[7:0];
         // Hardware set wins over write-one clear
         sts_reg <= (sts_reg & ~(wr_sts ? PWDATA[1:0] : 2'b00)) | {RETURN_DONE, start};
         if (wr_mask) mask_reg <= PWDATA[1:0];
         if (rd_setup) rdata_reg <= rd_mux;
      end
   end
   always_comb begin
      rd_mux = '0;
      unique case (a)
         mih_pkg::ADDR_ENABLE: rd_mux[7:0] = {global_reg, en_reg[6:0]};
         mih_pkg::ADDR_ENABLE_EXT: rd_mux[N-8:0] = en_reg[N-1:7];
         mih_pkg::ADDR_PRIO: rd_mux[6:0] = prio_reg[6:0];
         mih_pkg::ADDR_PRIO_EXT: rd_mux[N-8:0] = prio_reg[N-1:7];
         mih_pkg::ADDR_TIMER_CTRL: rd_mux[3:0] = {pend_reg[mih_pkg::SRC_EXT1], tctl_reg[2],
            pend_reg[mih_pkg::SRC_EXT0], tctl_reg[0]};
         mih_pkg::ADDR_EXT_CFG: rd_mux[7:0] = cfg_reg;
         mih_pkg::ADDR_PENDING: rd_mux[N-1:0] = pend_reg;
         mih_pkg::ADDR_STATUS: rd_mux[1:0] = sts_reg;
         mih_pkg::ADDR_MASK: rd_mux[1:0] = mask_reg;
         mih_pkg::ADDR_VECTOR: rd_mux[15:0] = vec_reg;
         default: rd_mux = '0;
      endcase
   end
   assign IRQ = |(sts_reg & mask_reg);
   ////////////////////////////////////////////////////////////////////
   // Vectoring sequencer and running level stack
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         call_reg <= 1'b0;
         call_cnt_reg <= '0;
         call_src_reg <= '0;
         call_high_reg <= 1'b0;
         vec_reg <= '0;
         level_reg <= '0;
         block_reg <= 1'b0;
      end else if (CLK_EN) begin
         if (start) begin
            call_reg <= 1'b1;
            call_cnt_reg <= '0;
            call_src_reg <= req.src;
            call_high_reg <= req.high;
            vec_reg <= vec_calc;
         end else if (call_last) begin
            call_reg <= 1'b0;
            if (call_high_reg) level_reg[1] <= 1'b1;
            else level_reg[0] <= 1'b1;
         end else if (call_reg) begin
            call_cnt_reg <= call_cnt_reg + 3'd1;
         end
         if (RETURN_DONE && !call_reg) begin
            if (level_reg[1]) level_reg[1] <= 1'b0;
            else level_reg[0] <= 1'b0;
            block_reg <= 1'b1;
         end else if (INSTR_DONE) begin
            block_reg <= 1'b0;
         end
      end
   end
   assign CALL_REQ = call_last;
   assign CALL_VECTOR = vec_reg;
   ////////////////////////////////////////////////////////////////////
   // Checks
   a_call_after_five: assert property (@(posedge CLK) disable iff (!RESET_N)
      (start && CLK_EN) ##1 CLK_EN [*4] |=> CALL_REQ)
      else $error("call not issued five cycles after detect");
   a_call_once: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CALL_REQ && CLK_EN) |=> !CALL_REQ)
      else $error("call pulse longer than one cycle");
   a_vector_match: assert property (@(posedge CLK) disable iff (!RESET_N)
      CALL_REQ |-> CALL_VECTOR == mih_pkg::VECTOR_BASE + 16'(call_src_reg) * mih_pkg::VECTOR_STEP)
      else $error("vector does not match source");
   a_vector_stable: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && call_reg) |=> $stable(CALL_VECTOR))
      else $error("vector moved during call");
   a_request_raised: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && INSTR_DONE && req.valid && level_reg == 2'b00 && !call_reg && !block_reg) |=> call_reg)
      else $error("enabled pending source not taken");
   a_no_global_req: assert property (@(posedge CLK) disable iff (!RESET_N)
      !global_reg |-> !start)
      else $error("request started with global enable off");
   a_global_gates: assert property (@(posedge CLK) disable iff (!RESET_N)
      !global_reg |-> !req.valid)
      else $error("request raised with global enable off");
   a_disabled_ignored: assert property (@(posedge CLK) disable iff (!RESET_N)
      start |-> en_reg[req.src] && pend_reg[req.src])
      else $error("disabled source started");
   a_high_not_pre: assert property (@(posedge CLK) disable iff (!RESET_N)
      level_reg[1] |-> !start)
      else $error("high routine preempted");
   a_low_no_pre: assert property (@(posedge CLK) disable iff (!RESET_N)
      (level_reg[0] && start) |-> req.high)
      else $error("low routine preempted by equal level");
   a_high_first: assert property (@(posedge CLK) disable iff (!RESET_N)
      (start && live_hi != '0) |-> req.high && live_hi[req.src])
      else $error("low source chosen over high");
   a_return_pops: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && RETURN_DONE && !call_reg && level_reg != 2'b00) |=> level_reg != $past(level_reg))
      else $error("return left running level in place");
   a_block_after_ret: assert property (@(posedge CLK) disable iff (!RESET_N)
      (RETURN_DONE && !call_reg && CLK_EN) |=> !start)
      else $error("vectored without one instruction");
   a_block_released: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && block_reg && INSTR_DONE && !RETURN_DONE) |=> !block_reg)
      else $error("return hold not released");
   a_soft_flag_kept: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && call_last && !wr_pend) |=> ($past(pend_reg[N-1:3]) & ~pend_reg[N-1:3]) == '0)
      else $error("software flag cleared by vectoring");
   a_soft_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && wr_pend && PWDATA[31] && !PWDATA[4] && !SRC_EVENT[4]) |=> !pend_reg[4])
      else $error("software clear lost");
   a_soft_set: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && wr_pend && PWDATA[4]) |=> pend_reg[4])
      else $error("software set lost");
   a_event_sets: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && SRC_EVENT[4]) |=> pend_reg[4])
      else $error("event lost");
   a_edge_sets: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && edge0 && act0 && !ext_prev_reg[0]) |=> pend_reg[mih_pkg::SRC_EXT0])
      else $error("active edge not captured");
   a_edge_cleared: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && call_last && call_src_reg == 5'(mih_pkg::SRC_EXT0) && edge0 && !ext_set[0] && !SRC_EVENT[0]
      && !wr_pend) |=> !pend_reg[mih_pkg::SRC_EXT0]) else $error("edge flag not cleared");
   a_level_mirror: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && !edge0) |=> pend_reg[mih_pkg::SRC_EXT0] == $past(act0))
      else $error("level flag not mirrored");
   a_level_mirror_one: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && !edge1) |=> pend_reg[mih_pkg::SRC_EXT1] == $past(act1))
      else $error("level flag one not mirrored");
   a_timer_flags: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CLK_EN && rd_setup && a == mih_pkg::ADDR_TIMER_CTRL) |=>
      PRDATA[mih_pkg::EXT0_FLAG_BIT] == $past(pend_reg[mih_pkg::SRC_EXT0])
      && PRDATA[mih_pkg::EXT1_FLAG_BIT] == $past(pend_reg[mih_pkg::SRC_EXT1])) else $error("flag bits misplaced");
endmodule
`default_nettype wire

// ---- tb/mih_cpu_model.sv ----
// CPU sequencer model: instruction completion and interrupt return pulses
`timescale 1ns/1ns
`default_nettype none
module mih_cpu_model #(
   parameter int INSTR_PERIOD = 7,
   parameter int ISR_CYCLES = 20
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic CALL_REQ,
   output logic INSTR_DONE,
   output logic RETURN_DONE
);
   int instr_cnt;
   int isr_cnt;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         instr_cnt <= 0;
         isr_cnt <= 0;
         INSTR_DONE <= 1'b0;
         RETURN_DONE <= 1'b0;
      end else begin
         // Instruction boundaries keep coming, inside routines too
         instr_cnt <= (instr_cnt == INSTR_PERIOD - 1) ? 0 : instr_cnt + 1;
         INSTR_DONE <= (instr_cnt == INSTR_PERIOD - 2);
         // Routine body runs, then ends in a return
         if (CALL_REQ) begin
            isr_cnt <= ISR_CYCLES;
         end else if (isr_cnt != 0) begin
            isr_cnt <= isr_cnt - 1;
         end
         RETURN_DONE <= (isr_cnt == 1);
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb_mcu_interrupt_handler.sv ----
// Testbench: register access, vectoring, priority and external input sensing
`timescale 1ns/1ns
`default_nettype none
module tb_mcu_interrupt_handler;
   logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, call_req, irq, instr_done, return_done, got, err_seen;
   logic [16:0] src_event = 17'h0;
   logic [7:0] port_pins = 8'h00;
   logic [15:0] call_vector, vec;
   int errors = 0, cmp_count = 0, cycles = 0;
   initial begin
      forever #4 clk = ~clk;
   end
   mih_top u_dut (.CLK(clk), .RESET_N(reset_n), .CLK_EN(1'b1), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr),
      .PRDATA(prdata), .SRC_EVENT(src_event), .PORT_PINS(port_pins), .INSTR_DONE(instr_done),
      .RETURN_DONE(return_done), .CALL_REQ(call_req), .CALL_VECTOR(call_vector), .IRQ(irq));
   mih_cpu_model u_cpu (.CLK(clk), .RESET_N(reset_n), .CALL_REQ(call_req), .INSTR_DONE(instr_done),
      .RETURN_DONE(return_done));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      err_seen = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge lets written state settle before any check
      @(posedge clk);
   endtask
   task automatic wait_call(input int lim);
      got = 1'b0;
      vec = 16'h0;
      for (int i = 0; i < lim && !got; i++) begin
         @(posedge clk);
         if (call_req === 1'b1) begin
            got = 1'b1;
            vec = call_vector;
         end
      end
   endtask
   function automatic logic [15:0] vec_of(input int s);
      return mih_pkg::VECTOR_BASE + mih_pkg::VECTOR_STEP * s[15:0];
   endfunction
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         wrap_up();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      apb(1'b0, mih_pkg::ADDR_ENABLE, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h030, 32'h0);
      check({rd[30:0], err_seen}, 32'h1);
      ///////////////////////////////////////////////////////////////
      @(posedge clk) src_event <= 17'h00010;
      @(posedge clk) src_event <= 17'h0;
      apb(1'b0, mih_pkg::ADDR_PENDING, 32'h0);
      check(rd & 32'h10, 32'h10);
      wait_call(30);
      check(got, 1'b0);
      apb(1'b1, mih_pkg::ADDR_ENABLE, 32'h10);
      wait_call(30);
      check(got, 1'b0);
      apb(1'b1, mih_pkg::ADDR_ENABLE, 32'h90);
      wait_call(30);
      check({got, vec}, {1'b1, vec_of(4)});
      apb(1'b0, mih_pkg::ADDR_PENDING, 32'h0);
      check(rd & 32'h10, 32'h10);
      wait_call(60);
      check({got, vec}, {1'b1, vec_of(4)});
      apb(1'b1, mih_pkg::ADDR_PENDING, 32'h80000000);
      wait_call(60);
      check(got, 1'b0);
      apb(1'b1, mih_pkg::ADDR_MASK, 32'h1);
      check(irq, 1'b1);
      apb(1'b1, mih_pkg::ADDR_STATUS, 32'h3);
      check(irq, 1'b0);
      ///////////////////////////////////////////////////////////////
      apb(1'b1, mih_pkg::ADDR_ENABLE, 32'h30);
      apb(1'b1, mih_pkg::ADDR_PRIO, 32'h20);
      apb(1'b1, mih_pkg::ADDR_PENDING, 32'h30);
      apb(1'b1, mih_pkg::ADDR_ENABLE, 32'hb0);
      wait_call(30);
      check({got, vec}, {1'b1, vec_of(5)});
      apb(1'b1, mih_pkg::ADDR_PENDING, 32'h80000010);
      wait_call(60);
      check({got, vec}, {1'b1, vec_of(4)});
      apb(1'b1, mih_pkg::ADDR_PENDING, 32'h80000000);
      wait_call(60);
      ///////////////////////////////////////////////////////////////
      apb(1'b1, mih_pkg::ADDR_ENABLE, 32'h01);
      apb(1'b1, mih_pkg::ADDR_EXT_CFG, 32'h08);
      @(posedge clk) port_pins <= 8'h01;
      apb(1'b0, mih_pkg::ADDR_TIMER_CTRL, 32'h0);
      check(rd, 32'h02);
      @(posedge clk) port_pins <= 8'h00;
      apb(1'b0, mih_pkg::ADDR_TIMER_CTRL, 32'h0);
      check(rd, 32'h08);
      apb(1'b1, mih_pkg::ADDR_TIMER_CTRL, 32'h01);
      @(posedge clk) port_pins <= 8'h01;
      @(posedge clk) port_pins <= 8'h00;
      apb(1'b0, mih_pkg::ADDR_TIMER_CTRL, 32'h0);
      check(rd, 32'h0b);
      apb(1'b1, mih_pkg::ADDR_ENABLE, 32'h81);
      wait_call(30);
      check({got, vec}, {1'b1, vec_of(0)});
      apb(1'b0, mih_pkg::ADDR_TIMER_CTRL, 32'h0);
      check(rd, 32'h09);
      apb(1'b1, mih_pkg::ADDR_EXT_CFG, 32'h58);
      @(posedge clk) port_pins <= 8'h20;
      apb(1'b0, mih_pkg::ADDR_TIMER_CTRL, 32'h0);
      check(rd, 32'h01);
      @(posedge clk) port_pins <= 8'h00;
      apb(1'b0, mih_pkg::ADDR_TIMER_CTRL, 32'h0);
      check(rd, 32'h09);
      wrap_up();
   end
endmodule
`default_nettype wire
